// ===== rtl/rfm_top.sv
// Functional notes
// - fraction is upper part times 2^13 plus lower
// - optional reference doubler before phase detector
// - each imminent slip adds one cell, seven max
// - past target, drop extra cells one by one
// - slip reduction enabled only by bit 28
// - deviation word 16 bits, shift 4 bits
// - step is deviation word shifted by shift
// - frequency keying adds or subtracts step from center
// - phase offset is 12-bit phase value fraction
// - pin high advances phase, low retards it
// - five waveform types supported
// - hop interval is first times second divider
// - 20-bit step count sets hops per ramp
// - single ramp steps up then holds
// - single triangle steps down after up run
// - single sawtooth restores start value then holds
// - continuous sawtooth repeats until ramp disabled
// - continuous triangle alternates direction until disabled
// - low three word bits select destination register
`timescale 1ns/1ps
`include "rfm_cfg.svh"

module rfm_top #(
  parameter int TIMER_W = 12,
  parameter int STEP_W = 20
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tx_data,
  input wire logic slip_imminent,
  input wire logic vco_past_target,
  output logic [11:0] n_int,
  output logic [24:0] n_frac,
  output logic [11:0] phase_offset,
  output logic ref_double,
  output logic ref_halve,
  output logic [2:0] slip_cells,
  output logic ramp_busy
);

  localparam int NW = 37;

  // two-stage synchronisers for the pin-level inputs
  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;
  logic tx_s;
  logic slip_s;
  logic past_s;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_meta_q <= 3'h0;
      pin_sync_q <= 3'h0;
    end else begin
      pin_meta_q <= {vco_past_target, slip_imminent, tx_data};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign tx_s = pin_sync_q[0];
  assign slip_s = pin_sync_q[1];
  assign past_s = pin_sync_q[2];

  // register bank
  logic [31:0] reg_q [`RFM_NREGS];
  logic [31:0] reg_d [`RFM_NREGS];

  // bus write channel
  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic [5:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic wr_direct;
  logic wr_serial;
  logic [2:0] wr_idx;
  logic [2:0] ser_idx;

  assign wr_idx = awaddr_q[4:2];
  assign wr_direct = awaddr_q[5] == 1'b0 && awaddr_q[1:0] == 2'b00 && wr_idx != `RFM_SEL_NONE;
  assign wr_serial = awaddr_q == `RFM_SERIAL_OFF;
  assign ser_idx = wdata_q[`RFM_SEL_MSB:`RFM_SEL_LSB];

  always_comb begin
    aw_hold_d = aw_hold_q;
    w_hold_d = w_hold_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    for (int i = 0; i < `RFM_NREGS; i++) begin
      reg_d[i] = reg_q[i];
    end
    if (awready_q && s_axi_awvalid) begin
      aw_hold_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (wready_q && s_axi_wvalid) begin
      w_hold_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (aw_hold_q && w_hold_q && !bvalid_q) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = `RFM_RESP_OK;
      if (wr_direct) begin
        for (int b = 0; b < 4; b++) begin
          if (wstrb_q[b]) begin
            reg_d[wr_idx][8*b +: 8] = wdata_q[8*b +: 8];
          end
        end
      end else if (wr_serial) begin
        // whole serial word lands where its low bits point
        if (ser_idx != `RFM_SEL_NONE) begin
          reg_d[ser_idx] = wdata_q;
        end
      end else begin
        bresp_d = `RFM_RESP_ERR;
      end
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    awready_d = !aw_hold_d && !bvalid_d;
    wready_d = !w_hold_d && !bvalid_d;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `RFM_RESP_OK;
      awaddr_q <= 6'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      for (int i = 0; i < `RFM_NREGS; i++) begin
        reg_q[i] <= `RFM_REG_RST;
      end
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      for (int i = 0; i < `RFM_NREGS; i++) begin
        reg_q[i] <= reg_d[i];
      end
    end
  end

  // decoded fields
  logic ramp_on;
  logic [NW-1:0] center;
  logic [11:0] phase_val;
  logic [TIMER_W-1:0] first_timer_divider;
  logic [TIMER_W-1:0] second_timer_divider;
  logic [15:0] deviation_word;
  logic [3:0] deviation_shift;
  logic [STEP_W-1:0] steps;
  logic [NW-1:0] step_val;
  logic ramp_div_mode;
  rfm_pkg::rfm_ramp_type_t rtype;
  rfm_pkg::rfm_key_mode_t kmode;

  assign ramp_on = reg_q[`RFM_R_MAIN][`RFM_RAMP_ON_BIT];
  assign center = {reg_q[`RFM_R_MAIN][`RFM_INT_MSB:`RFM_INT_LSB],
                   reg_q[`RFM_R_MAIN][`RFM_FMSB_MSB:`RFM_FMSB_LSB],
                   reg_q[`RFM_R_LSB][`RFM_FLSB_MSB:`RFM_FLSB_LSB]};
  assign phase_val = reg_q[`RFM_R_LSB][`RFM_PHASE_MSB:`RFM_PHASE_LSB];
  assign first_timer_divider = reg_q[`RFM_R_REF][`RFM_TDIV1_MSB:`RFM_TDIV1_LSB];
  assign second_timer_divider = reg_q[`RFM_R_CLK][`RFM_TDIV2_MSB:`RFM_TDIV2_LSB];
  assign ramp_div_mode = reg_q[`RFM_R_CLK][`RFM_CDM_MSB:`RFM_CDM_LSB] == `RFM_CDM_RAMP;
  assign deviation_word = reg_q[`RFM_R_DEVIATION][`RFM_DEVIATION_MSB:`RFM_DEVIATION_LSB];
  assign deviation_shift = reg_q[`RFM_R_DEVIATION][`RFM_SHIFT_MSB:`RFM_SHIFT_LSB];
  assign steps = reg_q[`RFM_R_STEP][`RFM_STEPS_MSB:`RFM_STEPS_LSB];
  assign rtype = rfm_pkg::rfm_ramp_type_t'(reg_q[`RFM_R_FUNC][`RFM_RTYPE_MSB:`RFM_RTYPE_LSB]);
  assign kmode = rfm_pkg::rfm_key_mode_t'(reg_q[`RFM_R_FUNC][`RFM_KEY_MSB:`RFM_KEY_LSB]);
  // signed word, sign-extended into the 37-bit divider scale
  assign step_val = {{(NW-16){deviation_word[15]}}, deviation_word} << deviation_shift;

  // hop timer, one mclk cycle stands for one comparison period
  logic [TIMER_W-1:0] t1_q, t1_d, t2_q, t2_d;
  logic tick;
  logic timer_run;

  assign timer_run = ramp_on && ramp_div_mode;

  always_comb begin
    t1_d = t1_q;
    t2_d = t2_q;
    tick = 1'b0;
    if (!timer_run) begin
      t1_d = TIMER_W'(1);
      t2_d = TIMER_W'(1);
    end else if (t1_q >= first_timer_divider) begin
      // a zero divider acts as one rather than stalling
      t1_d = TIMER_W'(1);
      if (t2_q >= second_timer_divider) begin
        t2_d = TIMER_W'(1);
        tick = 1'b1;
      end else begin
        t2_d = t2_q + TIMER_W'(1);
      end
    end else begin
      t1_d = t1_q + TIMER_W'(1);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      t1_q <= TIMER_W'(1);
      t2_q <= TIMER_W'(1);
    end else begin
      t1_q <= t1_d;
      t2_q <= t2_d;
    end
  end

  // waveform engine
  rfm_pkg::rfm_state_t state_q, state_d;
  logic [NW-1:0] acc_q, acc_d;
  logic [STEP_W-1:0] cnt_q, cnt_d;
  logic run_done;

  assign run_done = cnt_q >= steps;

  always_comb begin
    state_d = state_q;
    acc_d = acc_q;
    cnt_d = cnt_q;
    if (!ramp_on) begin
      state_d = rfm_pkg::st_idle;
      acc_d = center;
      cnt_d = '0;
    end else begin
      case (state_q)
        rfm_pkg::st_idle: begin
          state_d = rfm_pkg::st_up;
          acc_d = center;
          cnt_d = '0;
        end
        rfm_pkg::st_up: begin
          if (tick && !run_done) begin
            acc_d = acc_q + step_val;
            cnt_d = cnt_q + STEP_W'(1);
          end else if (tick) begin
            case (rtype)
              rfm_pkg::rt_single_tri, rfm_pkg::rt_cont_tri: begin
                state_d = rfm_pkg::st_down;
                acc_d = acc_q - step_val;
                cnt_d = STEP_W'(1);
              end
              rfm_pkg::rt_single_saw: begin
                state_d = rfm_pkg::st_hold;
                acc_d = center;
              end
              rfm_pkg::rt_cont_saw: begin
                acc_d = center;
                cnt_d = '0;
              end
              default: begin
                state_d = rfm_pkg::st_hold;
              end
            endcase
          end
        end
        rfm_pkg::st_down: begin
          if (tick && !run_done) begin
            acc_d = acc_q - step_val;
            cnt_d = cnt_q + STEP_W'(1);
          end else if (tick && rtype == rfm_pkg::rt_cont_tri) begin
            state_d = rfm_pkg::st_up;
            acc_d = acc_q + step_val;
            cnt_d = STEP_W'(1);
          end else if (tick) begin
            state_d = rfm_pkg::st_hold;
          end
        end
        rfm_pkg::st_hold: begin
          state_d = rfm_pkg::st_hold;
        end
        default: begin
          state_d = rfm_pkg::st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= rfm_pkg::st_idle;
      acc_q <= '0;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      acc_q <= acc_d;
      cnt_q <= cnt_d;
    end
  end

  // divider value, phase offset and status outputs
  logic [NW-1:0] nval_q, nval_d;
  logic [11:0] phase_q, phase_d;
  logic busy_q, busy_d;

  always_comb begin
    nval_d = center;
    phase_d = 12'h000;
    if (ramp_on) begin
      nval_d = acc_q;
    end else if (kmode == rfm_pkg::km_freq) begin
      nval_d = tx_s ? center + step_val : center - step_val;
    end
    if (kmode == rfm_pkg::km_phase) begin
      // offset in units of a full turn over 4096
      phase_d = tx_s ? phase_val : 12'h000 - phase_val;
    end
    busy_d = state_q == rfm_pkg::st_up || state_q == rfm_pkg::st_down;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      nval_q <= '0;
      phase_q <= 12'h000;
      busy_q <= 1'b0;
    end else begin
      nval_q <= nval_d;
      phase_q <= phase_d;
      busy_q <= busy_d;
    end
  end

  rfm_slip u_slip (
    .mclk(mclk),
    .rst(rst),
    .enable(reg_q[`RFM_R_REF][`RFM_SLIP_EN_BIT]),
    .slip_level(slip_s),
    .past_level(past_s),
    .cells(slip_cells)
  );

  // bus read channel
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;

  always_comb begin
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (arready_q && s_axi_arvalid) begin
      arready_d = 1'b0;
      rvalid_d = 1'b1;
      rresp_d = `RFM_RESP_OK;
      rdata_d = 32'h0000_0000;
      if (s_axi_araddr[5] == 1'b0 && s_axi_araddr[1:0] == 2'b00 && s_axi_araddr[4:2] != `RFM_SEL_NONE) begin
        rdata_d = reg_q[s_axi_araddr[4:2]];
      end else if (s_axi_araddr == `RFM_STATUS_OFF) begin
        rdata_d = {26'h0, busy_q, state_q == rfm_pkg::st_down, state_q == rfm_pkg::st_hold, slip_cells};
      end else if (s_axi_araddr == `RFM_NINT_OFF) begin
        rdata_d = {20'h0, nval_q[NW-1:25]};
      end else if (s_axi_araddr == `RFM_NFRAC_OFF) begin
        rdata_d = {7'h0, nval_q[24:0]};
      end else if (s_axi_araddr != `RFM_SERIAL_OFF) begin
        rresp_d = `RFM_RESP_ERR;
      end
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
      arready_d = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `RFM_RESP_OK;
    end else begin
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign n_int = nval_q[NW-1:25];
  assign n_frac = nval_q[24:0];
  assign phase_offset = phase_q;
  assign ref_double = reg_q[`RFM_R_REF][`RFM_DOUBLE_BIT];
  assign ref_halve = reg_q[`RFM_R_REF][`RFM_HALVE_BIT];
  assign ramp_busy = busy_q;

endmodule

// ===== rtl/rfm_cfg.svh
`ifndef RFM_CFG_SVH
`define RFM_CFG_SVH

// register map, byte addresses on the 32-bit bus
`define RFM_ADDR_W 6
`define RFM_NREGS 7
`define RFM_SERIAL_OFF 6'h20
`define RFM_STATUS_OFF 6'h24
`define RFM_NINT_OFF 6'h28
`define RFM_NFRAC_OFF 6'h2c
`define RFM_REG_RST 32'h0000_0000
`define RFM_RESP_OK 2'b00
`define RFM_RESP_ERR 2'b10

// serial word destination select
`define RFM_SEL_MSB 2
`define RFM_SEL_LSB 0
`define RFM_SEL_NONE 3'h7

// first register: ramp start, integer, upper fraction
`define RFM_RAMP_ON_BIT 31
`define RFM_INT_MSB 26
`define RFM_INT_LSB 15
`define RFM_FMSB_MSB 14
`define RFM_FMSB_LSB 3

// second register: lower fraction, phase value
`define RFM_FLSB_MSB 27
`define RFM_FLSB_LSB 15
`define RFM_PHASE_MSB 14
`define RFM_PHASE_LSB 3

// reference divider register
`define RFM_SLIP_EN_BIT 28
`define RFM_HALVE_BIT 21
`define RFM_DOUBLE_BIT 20
`define RFM_TDIV1_MSB 14
`define RFM_TDIV1_LSB 3

// function register
`define RFM_RTYPE_MSB 12
`define RFM_RTYPE_LSB 10
`define RFM_KEY_MSB 8
`define RFM_KEY_LSB 7

// clock register
`define RFM_CDM_MSB 20
`define RFM_CDM_LSB 19
`define RFM_CDM_RAMP 2'b11
`define RFM_TDIV2_MSB 18
`define RFM_TDIV2_LSB 7

// deviation and step registers
`define RFM_DEVIATION_MSB 18
`define RFM_DEVIATION_LSB 3
`define RFM_SHIFT_MSB 22
`define RFM_SHIFT_LSB 19
`define RFM_STEPS_MSB 22
`define RFM_STEPS_LSB 3

// register indices
`define RFM_R_MAIN 0
`define RFM_R_LSB 1
`define RFM_R_REF 2
`define RFM_R_FUNC 3
`define RFM_R_CLK 4
`define RFM_R_DEVIATION 5
`define RFM_R_STEP 6

`define RFM_FRAC_LO_W 13
`define RFM_MAX_CELLS 3'h7

`endif

// ===== rtl/rfm_pkg.sv
package rfm_pkg;

  typedef enum logic [2:0] {
    rt_single_ramp,
    rt_single_tri,
    rt_single_saw,
    rt_cont_saw,
    rt_cont_tri
  } rfm_ramp_type_t;

  typedef enum logic [1:0] {
    km_off,
    km_freq,
    km_phase
  } rfm_key_mode_t;

  typedef enum {
    st_idle,
    st_up,
    st_down,
    st_hold
  } rfm_state_t;

endpackage

// ===== rtl/rfm_slip.sv
`timescale 1ns/1ps
`include "rfm_cfg.svh"

module rfm_slip (
  input wire logic mclk,
  input wire logic rst,
  input wire logic enable,
  input wire logic slip_level,
  input wire logic past_level,
  output logic [2:0] cells
);

  logic slip_prev_q;
  logic releasing_q;
  logic releasing_d;
  logic [2:0] cells_q;
  logic [2:0] cells_d;

  always_comb begin
    cells_d = cells_q;
    releasing_d = releasing_q;
    if (!enable) begin
      cells_d = 3'h0;
      releasing_d = 1'b0;
    end else if (past_level || releasing_q) begin
      // shed one cell per clock once the target is overshot
      releasing_d = 1'b1;
      if (cells_q != 3'h0) begin
        cells_d = cells_q - 3'h1;
      end else begin
        releasing_d = 1'b0;
      end
    end else if (slip_level && !slip_prev_q && cells_q != `RFM_MAX_CELLS) begin
      cells_d = cells_q + 3'h1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cells_q <= 3'h0;
      releasing_q <= 1'b0;
      slip_prev_q <= 1'b0;
    end else begin
      cells_q <= cells_d;
      releasing_q <= releasing_d;
      slip_prev_q <= slip_level;
    end
  end

  assign cells = cells_q;

endmodule

// ===== verif/rfm_top_chk.sv
`timescale 1ns/1ps
module rfm_top_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_rresp,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [2:0] slip_cells
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_resp_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid
    && s_axi_awready && s_axi_wready)
    else $error("write channel not freed after response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data late");
  a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not freed");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read returned data");
  a_cells_climb: assert property (slip_cells > $past(slip_cells) |-> slip_cells == $past(slip_cells) + 3'h1)
    else $error("cells added more than one");
  a_cells_drop: assert property (slip_cells < $past(slip_cells) |-> slip_cells == $past(slip_cells) - 3'h1
    || slip_cells == 3'h0)
    else $error("cells released more than one");
endmodule

bind rfm_top rfm_top_chk i_rfm_top_chk (.*);

// ===== verif/rfm_loop_model.sv
`timescale 1ns/1ps
module rfm_loop_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic tx_cmd,
  input wire logic slip_run,
  input wire logic past_cmd,
  output logic tx_data,
  output logic slip_imminent,
  output logic vco_past_target
);
  logic [1:0] ph_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ph_q <= 2'h0;
    end else begin
      ph_q <= slip_run ? ph_q + 2'h1 : 2'h0;
    end
  end
  // warnings two cycles wide so the two-flop sync never drops one
  assign slip_imminent = ph_q[1];
  assign vco_past_target = past_cmd;
  assign tx_data = tx_cmd;
endmodule

// ===== verif/tb_rfm_top.sv
`timescale 1ns/1ps
module tb_rfm_top;
  typedef struct {logic wr; logic [5:0] a; logic [31:0] d; logic [1:0] r; logic [31:0] q;} rfm_row_t;
  localparam logic [36:0] CTR = {12'h079, 25'h00a3d70};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] s_axi_awaddr = 6'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b1;
  logic [5:0] s_axi_araddr = 6'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b1;
  logic tx_cmd = 1'b0, slip_run = 1'b0, past_cmd = 1'b0;
  logic tx_data, slip_imminent, vco_past_target;
  logic [11:0] n_int;
  logic [24:0] n_frac;
  logic [11:0] phase_offset;
  logic ref_double, ref_halve, ramp_busy;
  logic [2:0] slip_cells;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  rfm_row_t rows [12] = '{
    '{1'h1, 6'h04, 32'h0eb82000, 2'h0, 32'h0},
    '{1'h1, 6'h00, 32'h003c8288, 2'h0, 32'h0},
    '{1'h1, 6'h10, 32'h00180100, 2'h0, 32'h0},
    '{1'h1, 6'h18, 32'h00000018, 2'h0, 32'h0},
    '{1'h1, 6'h20, 32'h0010002d, 2'h0, 32'h0},
    '{1'h1, 6'h20, 32'hffffffff, 2'h0, 32'h0},
    '{1'h1, 6'h24, 32'h00000001, 2'h2, 32'h0},
    '{1'h1, 6'h34, 32'h00000001, 2'h2, 32'h0},
    '{1'h0, 6'h28, 32'h0, 2'h0, 32'h00000079},
    '{1'h0, 6'h2c, 32'h0, 2'h0, 32'h000a3d70},
    '{1'h0, 6'h3c, 32'h0, 2'h2, 32'h0},
    '{1'h0, 6'h20, 32'h0, 2'h0, 32'h0}};

  rfm_top i_rfm_top (.*);
  rfm_loop_model i_rfm_loop_model (.*);

  always #12.5 mclk = ~mclk;

  task automatic check(input string nm, input logic [36:0] seen, input logic [36:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // bready and rready stay high: the master is always ready for answers
  task automatic wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask

  task automatic rd(input logic [5:0] a, output logic [1:0] r, output logic [31:0] q);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    r = s_axi_rresp;
    q = s_axi_rdata;
  endtask

  task automatic wok(input logic [5:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    check("bresp", r, 2'h0);
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      give_verdict();
    end
  end

  initial begin
    logic [1:0] r;
    logic [31:0] q;
    logic [36:0] mx;
    int n;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    check("n_reset", {n_int, n_frac}, 37'h0);
    check("arready_reset", s_axi_arready, 1'b1);
    cyc(2);
    $display("test reset done");
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d, r);
      else rd(rows[i].a, r, q);
      check("resp", r, rows[i].r);
      if (!rows[i].wr) check("rdata", q, rows[i].q);
    end
    check("n_center", {n_int, n_frac}, CTR);
    $display("test register rows done");
    wok(6'h0c, 32'h000000c0);
    tx_cmd <= 1'b1;
    cyc(6);
    check("freq_key_high", {n_int, n_frac}, CTR + 37'h14);
    tx_cmd <= 1'b0;
    cyc(6);
    check("freq_key_low", {n_int, n_frac}, CTR - 37'h14);
    wok(6'h0c, 32'h00000140);
    tx_cmd <= 1'b1;
    cyc(6);
    check("phase_key_high", phase_offset, 12'h400);
    tx_cmd <= 1'b0;
    cyc(6);
    check("phase_key_low", phase_offset, 12'hc00);
    $display("test keying done");
    wok(6'h08, 32'h00000018);
    for (int t = 0; t < 5; t++) begin
      wok(6'h0c, 32'h40 | (32'(t) << 10));
      wok(6'h00, 32'h803c8288);
      n = 0;
      while ({n_int, n_frac} == CTR && n < 50) begin
        cyc(1);
        n++;
      end
      mx = {n_int, n_frac};
      n = 0;
      while ({n_int, n_frac} == mx && n < 50) begin
        cyc(1);
        n++;
      end
      check("hop_gap", 37'(n), 37'h6);
      for (int k = 0; k < 60; k++) begin
        cyc(1);
        if ({n_int, n_frac} > mx) mx = {n_int, n_frac};
      end
      check("ramp_top", mx, CTR + 37'h3c);
      if (t < 3) begin
        check("ramp_end", {n_int, n_frac}, (t == 0) ? CTR + 37'h3c : CTR);
        check("busy_end", ramp_busy, 1'b0);
      end else begin
        check("busy_run", ramp_busy, 1'b1);
      end
      wok(6'h00, 32'h003c8288);
      cyc(3);
      check("ramp_stop", {n_int, n_frac}, CTR);
      $display("test ramp type %0d done", t);
    end
    // without ramp divider mode the timer never ticks
    wok(6'h10, 32'h00000100);
    wok(6'h00, 32'h803c8288);
    cyc(20);
    check("ramp_nomode", {n_int, n_frac}, CTR);
    wok(6'h00, 32'h003c8288);
    wok(6'h10, 32'h00180100);
    wok(6'h08, 32'h10000018);
    slip_run <= 1'b1;
    cyc(40);
    slip_run <= 1'b0;
    cyc(4);
    check("cells_max", slip_cells, 3'h7);
    past_cmd <= 1'b1;
    cyc(12);
    check("cells_off", slip_cells, 3'h0);
    past_cmd <= 1'b0;
    wok(6'h08, 32'h00000018);
    slip_run <= 1'b1;
    cyc(20);
    slip_run <= 1'b0;
    cyc(4);
    check("cells_dis", slip_cells, 3'h0);
    $display("test slip done");
    wok(6'h08, 32'h00100018);
    cyc(2);
    check("ref_dbl", {ref_double, ref_halve}, 2'h2);
    wok(6'h08, 32'h00200018);
    cyc(2);
    check("ref_hlv", {ref_double, ref_halve}, 2'h1);
    $display("test reference done");
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    cyc(2);
    check("n_rerst", {n_int, n_frac}, 37'h0);
    $display("test second reset done");
    give_verdict();
  end
endmodule
